// ### src/atr_pkg.sv
// Purpose: Shared constants and types for the address lookup table readback block
// Assumes: 32-bit APB data, one aligned word per register, byte address = 4 * index
// Notes:   Table entries are stored in the same layout as the two read-data words
package atr_pkg;

  // ==========================================================================
  // Register indices (byte address is the index shifted left by two)
  localparam int          ATR_IW        = 14;
  localparam logic [13:0] ATR_IDX_CMD   = 14'h1804;
  localparam logic [13:0] ATR_IDX_RD_LO = 14'h1805;
  localparam logic [13:0] ATR_IDX_RD_HI = 14'h1806;
  localparam logic [13:0] ATR_IDX_STS   = 14'h1808;
  localparam logic [13:0] ATR_IDX_CFG   = 14'h1810;
  localparam logic [1:0]  ATR_ALIGN     = 2'h0;

  // ==========================================================================
  // Field positions of the high read-data word
  localparam int ATR_B_EOT     = 27;
  localparam int ATR_B_VALID   = 26;
  localparam int ATR_B_AGE1    = 25;
  localparam int ATR_B_STATIC  = 24;
  localparam int ATR_B_AGE0    = 23;
  localparam int ATR_B_PRIO_EN = 22;
  localparam int ATR_PRIO_LSB  = 19;
  localparam int ATR_PORT_LSB  = 16;
  localparam int ATR_MACHI_W   = 16;
  localparam int ATR_HI_OFS    = 32;
  localparam int ATR_EW        = 64;

  // Command, status and configuration bits
  localparam int ATR_CMD_FIRST = 0;
  localparam int ATR_CMD_NEXT  = 1;
  localparam int ATR_STS_PEND  = 0;
  localparam int ATR_STS_INIT  = 1;
  localparam int ATR_CFG_DAPF  = 0;

  // Reset values and encodings
  localparam logic [31:0] ATR_RD_LO_RST = 32'h0000_0000;
  localparam logic [31:0] ATR_RD_HI_RST = 32'h0000_0000;
  localparam logic [1:0]  ATR_AGE_DEAD  = 2'h0;
  localparam logic [1:0]  ATR_AGE_STEP  = 2'h1;

  typedef enum {ST_INIT, ST_IDLE, ST_SRCH_RD, ST_SRCH_CHK, ST_AGE_RD, ST_AGE_CHK, ST_AGE_WR}
    atr_scan_state_t;

  // Port code to port set mask (bit n = port n, codes 4 to 7 set several bits); reserved code maps to none
  function automatic logic [2:0] atr_port_map(input logic [2:0] code);
    case (code)
      3'h0:    atr_port_map = 3'h1;
      3'h1:    atr_port_map = 3'h2;
      3'h2:    atr_port_map = 3'h4;
      3'h4:    atr_port_map = 3'h3;
      3'h5:    atr_port_map = 3'h5;
      3'h6:    atr_port_map = 3'h6;
      3'h7:    atr_port_map = 3'h7;
      default: atr_port_map = 3'h0;
    endcase
  endfunction

endpackage

// ### src/atr_mem_if.sv
// Purpose: Carries the table memory ports between the bank, scanner and memory
// Assumes: Read data arrive one clock after the address
// Notes:   Scanner owns port A reads, the bank owns the write port and port B
`timescale 1ns/1ps
interface atr_mem_if #(parameter int AW = 8);
  logic          wr_en;
  logic [AW-1:0] wr_addr;
  logic [63:0]   wr_data;
  logic [AW-1:0] rda_addr;
  logic [63:0]   rda_data;
  logic [AW-1:0] rdb_addr;
  logic [63:0]   rdb_data;

  modport mem  (input wr_en, wr_addr, wr_data, rda_addr, rdb_addr, output rda_data, rdb_data);
  modport scan (output rda_addr, input rda_data);
  modport bank (output wr_en, wr_addr, wr_data, rdb_addr, input rdb_data);
endinterface

// ### src/atr_table_mem.sv
// Purpose: Entry storage for the address lookup table, one write and two read ports
// Assumes: Contents are cleared by the scanner after reset, not by this array
// Notes:   Read data come out of registers
`timescale 1ns/1ps
module atr_table_mem #(
  parameter int AW = 8
) (
  // Clock
  input wire logic pclk,
  // Memory ports
  atr_mem_if.mem   m
);
  import atr_pkg::*;

  logic [ATR_EW-1:0] ram [0:(1<<AW)-1];

  // ==========================================================================
  // Write port; no reset so the array maps onto plain RAM
  always_ff @(posedge pclk)
  begin
    if (m.wr_en)
    begin
      ram[m.wr_addr] <= m.wr_data;
    end
  end

  // Registered read ports
  always_ff @(posedge pclk)
  begin
    m.rda_data <= ram[m.rda_addr];
    m.rdb_data <= ram[m.rdb_addr];
  end

endmodule

// ### src/atr_scan.sv
// Purpose: Walks the table for get-first/get-next searches, aging and clearing
// Assumes: External writes take the write port first; this block then waits
// Notes:   One entry is examined every two clocks; an aging write-back adds a third
`timescale 1ns/1ps
module atr_scan #(
  parameter int AW = 8
) (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // Command from the register bank
  input  wire logic              cmd_valid,
  input  wire logic              cmd_first,
  output logic                   cmd_ready,
  input  wire logic              age_tick,
  // Write request toward the shared write port
  output logic                   swr_en,
  output logic [AW-1:0]          swr_addr,
  output logic [63:0]            swr_data,
  input  wire logic              wr_stall,
  // Search result
  output logic                   done_q,
  output logic [63:0]            done_data_q,
  output logic                   done_eot_q,
  output logic                   init_done_q,
  // Memory read port A
  atr_mem_if.scan                m
);
  import atr_pkg::*;

  localparam logic [AW-1:0] LAST = '1;

  atr_scan_state_t state_q;
  logic [AW-1:0]   idx_q;
  logic [AW-1:0]   next_q;
  logic            eot_q;
  logic            age_pend_q;
  logic [63:0]     age_word_q;
  logic [1:0]      age_cur;
  logic            entry_valid;
  logic            entry_static;

  assign m.rda_addr   = idx_q;
  assign cmd_ready    = (state_q == ST_IDLE);
  assign entry_valid  = m.rda_data[ATR_HI_OFS+ATR_B_VALID];
  assign entry_static = m.rda_data[ATR_HI_OFS+ATR_B_STATIC];
  assign age_cur      = {m.rda_data[ATR_HI_OFS+ATR_B_AGE1], m.rda_data[ATR_HI_OFS+ATR_B_AGE0]};

  // Write requests: zero fill after reset, aged entry write-back otherwise
  assign swr_en   = (state_q == ST_INIT) || (state_q == ST_AGE_WR);
  assign swr_addr = idx_q;
  assign swr_data = (state_q == ST_INIT) ? '0 : age_word_q;

  // ==========================================================================
  // Aging request; a tick landing as the sweep starts is kept (set wins)
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      age_pend_q <= 1'b0;
    else if (age_tick)
      age_pend_q <= 1'b1;
    else if (state_q == ST_IDLE && !cmd_valid)
      age_pend_q <= 1'b0;
  end

  // Aged copy of the entry under examination
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      age_word_q <= '0;
    else if (state_q == ST_AGE_CHK)
    begin
      age_word_q <= m.rda_data;
      if (age_cur == ATR_AGE_DEAD)
        age_word_q[ATR_HI_OFS+ATR_B_VALID] <= 1'b0;
      else
        {age_word_q[ATR_HI_OFS+ATR_B_AGE1], age_word_q[ATR_HI_OFS+ATR_B_AGE0]}
          <= age_cur - ATR_AGE_STEP;
    end
  end

  // Search, sweep and clear sequencer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q     <= ST_INIT;
      idx_q       <= '0;
      next_q      <= '0;
      eot_q       <= 1'b0;
      done_q      <= 1'b0;
      done_data_q <= '0;
      done_eot_q  <= 1'b0;
      init_done_q <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      case (state_q)
        ST_INIT:
        begin
          if (!wr_stall)
          begin
            idx_q <= idx_q + 1'b1;
            if (idx_q == LAST)
            begin
              init_done_q <= 1'b1;
              state_q     <= ST_IDLE;
            end
          end
        end
        ST_IDLE:
        begin
          if (cmd_valid && !cmd_first && eot_q)
          begin
            // Walk already finished: answer end of table straight away
            done_q      <= 1'b1;
            done_data_q <= '0;
            done_eot_q  <= 1'b1;
          end
          else if (cmd_valid)
          begin
            idx_q   <= cmd_first ? '0 : next_q;
            eot_q   <= 1'b0;
            state_q <= ST_SRCH_RD;
          end
          else if (age_pend_q)
          begin
            idx_q   <= '0;
            state_q <= ST_AGE_RD;
          end
        end
        ST_SRCH_RD:
          state_q <= ST_SRCH_CHK;
        ST_SRCH_CHK:
        begin
          if (entry_valid || idx_q == LAST)
          begin
            done_q      <= 1'b1;
            done_data_q <= entry_valid ? m.rda_data : '0;
            done_eot_q  <= (idx_q == LAST);
            eot_q       <= (idx_q == LAST);
            next_q      <= idx_q + 1'b1;
            state_q     <= ST_IDLE;
          end
          else
          begin
            idx_q   <= idx_q + 1'b1;
            state_q <= ST_SRCH_RD;
          end
        end
        ST_AGE_RD:
          state_q <= ST_AGE_CHK;
        ST_AGE_CHK:
        begin
          // Static entries are never aged
          if (entry_valid && !entry_static)
            state_q <= ST_AGE_WR;
          else if (idx_q == LAST)
            state_q <= ST_IDLE;
          else
          begin
            idx_q   <= idx_q + 1'b1;
            state_q <= ST_AGE_RD;
          end
        end
        ST_AGE_WR:
        begin
          if (!wr_stall)
          begin
            idx_q   <= idx_q + 1'b1;
            state_q <= (idx_q == LAST) ? ST_IDLE : ST_AGE_RD;
          end
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================================
  property p_static_not_aged;
    @(posedge pclk) disable iff (!presetn)
    (state_q == ST_AGE_CHK && entry_static) |=> (state_q != ST_AGE_WR);
  endproperty
  a_static_not_aged: assert property (p_static_not_aged)
    else $error("static entry entered aging write-back");

endmodule

// ### src/atr_bank.sv
// Functional notes
// - Low read word holds first 32 MAC bits, bit 0 the multicast bit
// - Read words load only from a get-first or get-next search
// - Bit 27 set when search reaches table end, valid or not
// - Writing get-first or get-next clears the valid bit 26
// - Valid sets on found entry, stays clear when table end reached; the code sets it with bit 27 when the last entry is valid
// - Non-static entry: bit 25 is aging timer msb
// - Static entry: bit 25 overrides port state except disabled
// - Static entries never age; others removed after idle aging period
// - Non-static entry: bit 23 is aging timer lsb
// - Static entry: bit 23 filters matching destination packets
// - Bit 22 reports whether entry priority is enabled
// - Priority bits 21:19 used only with entry and global enables set
// - Bits 18:16 encode associated port set; 011 reserved
// - High read word bits 15:0 hold last 16 MAC bits
// - Pending flag self-clears when a table command completes
//
// Purpose: APB register bank for the address lookup table readback words
// Assumes: APB master holds requests stable; zero wait states
// Notes:   Also serves the forwarding lookup port from the same table
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
module atr_bank #(
  parameter int AW = 8
) (
  // Clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // APB slave
  input  wire logic [15:0]            paddr,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [31:0]            pwdata,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  // Entry writes from the learning engine
  input  wire logic                   tbl_wr_en,
  input  wire logic [AW-1:0]          tbl_wr_idx,
  input  wire logic [63:0]            tbl_wr_data,
  // Aging period tick
  input  wire logic                   age_tick,
  // Forwarding lookup
  input  wire logic                   fwd_req,
  input  wire logic [AW-1:0]          fwd_idx,
  output logic                        fwd_valid,
  output logic                        fwd_hit,
  output logic [2:0]                  fwd_port_map,
  output logic                        fwd_multi,
  output logic                        fwd_discard,
  output logic                        fwd_override,
  output logic                        fwd_prio_use,
  output logic [2:0]                  fwd_prio
);
  import atr_pkg::*;

  atr_mem_if #(.AW(AW)) mif ();

  logic [ATR_IW-1:0] idx;
  logic              hit;
  logic              wr_acc;
  logic              cmd_wr;
  logic              cmd_take;
  logic [31:0]       rd_mux;
  logic [31:0]       rd_lo_q;
  logic [31:0]       rd_hi_q;
  logic              pend_q;
  logic              cmd_first_q;
  logic              cmd_go_q;
  logic              dapf_q;
  logic [31:0]       prdata_q;
  logic              pslverr_q;
  logic              cmd_ready;
  logic              swr_en;
  logic [AW-1:0]     swr_addr;
  logic [63:0]       swr_data;
  logic              scan_done;
  logic [63:0]       scan_data;
  logic              scan_eot;
  logic              init_done;
  logic              fwd_v1_q;
  logic [31:0]       fhi;

  // ==========================================================================
  // Table storage and scanner
  atr_table_mem #(.AW(AW)) u_mem (
    .pclk (pclk),
    .m    (mif)
  );

  atr_scan #(.AW(AW)) u_scan (
    .pclk        (pclk),
    .presetn     (presetn),
    .cmd_valid   (cmd_go_q),
    .cmd_first   (cmd_first_q),
    .cmd_ready   (cmd_ready),
    .age_tick    (age_tick),
    .swr_en      (swr_en),
    .swr_addr    (swr_addr),
    .swr_data    (swr_data),
    .wr_stall    (tbl_wr_en),
    .done_q      (scan_done),
    .done_data_q (scan_data),
    .done_eot_q  (scan_eot),
    .init_done_q (init_done),
    .m           (mif)
  );

  // Write port: the learning engine wins, the scanner waits while it writes
  assign mif.wr_en    = tbl_wr_en || swr_en;
  assign mif.wr_addr  = tbl_wr_en ? tbl_wr_idx : swr_addr;
  assign mif.wr_data  = tbl_wr_en ? tbl_wr_data : swr_data;
  assign mif.rdb_addr = fwd_idx;

  // ==========================================================================
  // APB decode; only aligned words at known indices answer without error
  assign idx    = paddr[15:2];
  assign hit    = (paddr[1:0] == ATR_ALIGN) &&
                  (idx == ATR_IDX_CMD || idx == ATR_IDX_RD_LO || idx == ATR_IDX_RD_HI ||
                   idx == ATR_IDX_STS || idx == ATR_IDX_CFG);
  assign wr_acc = psel && penable && pwrite && hit;
  assign cmd_wr = wr_acc && (idx == ATR_IDX_CMD) &&
                  (pwdata[ATR_CMD_FIRST] || pwdata[ATR_CMD_NEXT]);
  // A command while one is pending, or before the clear finishes, is dropped
  assign cmd_take = cmd_wr && !pend_q && init_done;

  assign pready  = 1'b1;
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q && psel && penable;

  // Read mux; command bits are self-clearing and read as zero
  always_comb
  begin
    rd_mux = '0;
    case (idx)
      ATR_IDX_RD_LO: rd_mux = rd_lo_q;
      ATR_IDX_RD_HI: rd_mux = rd_hi_q;
      ATR_IDX_STS:
      begin
        rd_mux[ATR_STS_PEND] = pend_q;
        rd_mux[ATR_STS_INIT] = init_done;
      end
      ATR_IDX_CFG:   rd_mux[ATR_CFG_DAPF] = dapf_q;
      default:       rd_mux = '0;
    endcase
  end

  // Read data and error are captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q  <= '0;
      pslverr_q <= 1'b0;
    end
    else if (psel && !penable)
    begin
      prdata_q  <= pwrite ? '0 : (hit ? rd_mux : '0);
      pslverr_q <= !hit;
    end
  end

  // Global destination-address priority enable
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dapf_q <= 1'b0;
    else if (wr_acc && idx == ATR_IDX_CFG)
      dapf_q <= pwdata[ATR_CFG_DAPF];
  end

  // ==========================================================================
  // Command hand-off and pending flag
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pend_q      <= 1'b0;
      cmd_go_q    <= 1'b0;
      cmd_first_q <= 1'b0;
    end
    else
    begin
      if (cmd_take)
      begin
        pend_q      <= 1'b1;
        cmd_go_q    <= 1'b1;
        cmd_first_q <= pwdata[ATR_CMD_FIRST];   // First wins if both bits are set
      end
      else
      begin
        if (cmd_go_q && cmd_ready)
          cmd_go_q <= 1'b0;
        if (scan_done)
          pend_q <= 1'b0;
      end
    end
  end

  // Readback words: loaded only by a finished search, both in one edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rd_lo_q <= ATR_RD_LO_RST;
      rd_hi_q <= ATR_RD_HI_RST;
    end
    else if (scan_done)
    begin
      rd_lo_q                    <= scan_data[31:0];
      rd_hi_q                    <= scan_data[63:32];
      rd_hi_q[31:ATR_B_EOT+1]    <= '0;
      rd_hi_q[ATR_B_EOT]         <= scan_eot;
      rd_hi_q[ATR_B_VALID]       <= scan_data[ATR_HI_OFS+ATR_B_VALID];
    end
    else if (cmd_wr)
      rd_hi_q[ATR_B_VALID] <= 1'b0;
  end

  // ==========================================================================
  // Forwarding lookup: table read, then decode into flops two clocks after request
  assign fhi = mif.rdb_data[63:32];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fwd_v1_q     <= 1'b0;
      fwd_valid    <= 1'b0;
      fwd_hit      <= 1'b0;
      fwd_port_map <= '0;
      fwd_multi    <= 1'b0;
      fwd_discard  <= 1'b0;
      fwd_override <= 1'b0;
      fwd_prio_use <= 1'b0;
      fwd_prio     <= '0;
    end
    else
    begin
      fwd_v1_q     <= fwd_req;
      fwd_valid    <= fwd_v1_q;
      fwd_hit      <= fhi[ATR_B_VALID];
      fwd_port_map <= atr_port_map(fhi[ATR_PORT_LSB +: 3]);
      fwd_multi    <= fhi[ATR_PORT_LSB+2];
      fwd_discard  <= fhi[ATR_B_VALID] && fhi[ATR_B_STATIC] && fhi[ATR_B_AGE0];
      fwd_override <= fhi[ATR_B_VALID] && fhi[ATR_B_STATIC] && fhi[ATR_B_AGE1];
      fwd_prio_use <= fhi[ATR_B_VALID] && fhi[ATR_B_PRIO_EN] && dapf_q;
      fwd_prio     <= fhi[ATR_PRIO_LSB +: 3];
    end
  end

  // ==========================================================================
  // Checks
  property p_low_word;
    @(posedge pclk) disable iff (!presetn)
    scan_done |=> rd_lo_q == $past(scan_data[31:0]);
  endproperty
  a_low_word: assert property (p_low_word)
    else $error("low read word not loaded from search result");

  property p_load_by_cmd;
    @(posedge pclk) disable iff (!presetn)
    (rd_lo_q != $past(rd_lo_q)) |-> $past(scan_done);
  endproperty
  a_load_by_cmd: assert property (p_load_by_cmd)
    else $error("low read word changed without a search");

  property p_eot;
    @(posedge pclk) disable iff (!presetn)
    (scan_done && scan_eot) |=> rd_hi_q[ATR_B_EOT] ##1 rd_hi_q[ATR_B_EOT];
  endproperty
  a_eot: assert property (p_eot)
    else $error("end of table flag not shown");

  property p_cmd_clears_valid;
    @(posedge pclk) disable iff (!presetn)
    (cmd_wr && !scan_done) |=> !rd_hi_q[ATR_B_VALID];
  endproperty
  a_cmd_clears_valid: assert property (p_cmd_clears_valid)
    else $error("valid not cleared by command write");

  property p_valid_src;
    @(posedge pclk) disable iff (!presetn)
    scan_done |=> rd_hi_q[ATR_B_VALID] == $past(scan_data[ATR_HI_OFS+ATR_B_VALID]);
  endproperty
  a_valid_src: assert property (p_valid_src)
    else $error("valid flag does not match search outcome");

  property p_high_mac;
    @(posedge pclk) disable iff (!presetn)
    scan_done |=> rd_hi_q[15:0] == $past(scan_data[ATR_HI_OFS +: ATR_MACHI_W]);
  endproperty
  a_high_mac: assert property (p_high_mac)
    else $error("high MAC bits not loaded");

  property p_pend_clear;
    @(posedge pclk) disable iff (!presetn)
    cmd_take |=> pend_q ##[1:1000] !pend_q;
  endproperty
  a_pend_clear: assert property (p_pend_clear)
    else $error("pending flag did not self-clear");

  property p_filter;
    @(posedge pclk) disable iff (!presetn)
    fwd_v1_q |=> fwd_discard == ($past(fhi[ATR_B_VALID]) && $past(fhi[ATR_B_STATIC])
                                 && $past(fhi[ATR_B_AGE0]));
  endproperty
  a_filter: assert property (p_filter)
    else $error("discard does not follow static filter entry");

  property p_prio;
    @(posedge pclk) disable iff (!presetn)
    (fwd_valid && fwd_prio_use) |-> $past(dapf_q);
  endproperty
  a_prio: assert property (p_prio)
    else $error("entry priority used without global enable");

  property p_found;
    @(posedge pclk) disable iff (!presetn)
    scan_done && scan_data[ATR_HI_OFS+ATR_B_VALID];
  endproperty
  c_found: cover property (p_found);

  property p_end;
    @(posedge pclk) disable iff (!presetn)
    scan_done && scan_eot && !scan_data[ATR_HI_OFS+ATR_B_VALID];
  endproperty
  c_end: cover property (p_end);

  property p_dropped;
    @(posedge pclk) disable iff (!presetn)
    cmd_wr && pend_q;
  endproperty
  c_dropped: cover property (p_dropped);

endmodule

// ### test/atr_bank_test.sv
// Purpose: Self-checking APB bench for the table readback bank
// Assumes: AW=2, so the table has four entries and clears in a few cycles
// Notes:   Entries are loaded through the learning write port after init
`timescale 1ns/1ps
module atr_bank_test;
  import atr_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic        tbl_wr_en, fwd_req, fwd_valid, fwd_hit, fwd_multi, fwd_discard;
  logic        fwd_override, fwd_prio_use, e, age_tick;
  logic [1:0]  tbl_wr_idx, fwd_idx;
  logic [63:0] tbl_wr_data;
  logic [2:0]  fwd_port_map, fwd_prio;
  int          errors, cmp_count;
  // ==========================================================================
  // Design and clock
  atr_bank #(.AW(2)) atr_bank_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tbl_wr_en(tbl_wr_en), .tbl_wr_idx(tbl_wr_idx),
    .tbl_wr_data(tbl_wr_data), .age_tick(age_tick), .fwd_req(fwd_req), .fwd_idx(fwd_idx),
    .fwd_valid(fwd_valid), .fwd_hit(fwd_hit), .fwd_port_map(fwd_port_map),
    .fwd_multi(fwd_multi), .fwd_discard(fwd_discard), .fwd_override(fwd_override),
    .fwd_prio_use(fwd_prio_use), .fwd_prio(fwd_prio));
  initial begin pclk = 0; forever #4 pclk = ~pclk; end
  task automatic report_and_stop();
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer; waits on pready, takes data at that edge
  task automatic apb(input logic w, input logic [13:0] idx, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= {idx, ATR_ALIGN}; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin errors++; report_and_stop(); end
    r = prdata; e = pslverr; psel <= 1'b0; penable <= 1'b0;
  endtask
  // Poll status until the masked bits match; bounded so a hang ends the run
  task automatic wait_sts(input logic [31:0] m, input logic [31:0] v);
    int n;
    n = 0;
    do begin apb(1'b0, ATR_IDX_STS, 32'h0); n++; end while ((r & m) !== v && n < 200);
    if (n >= 200) begin errors++; report_and_stop(); end
  endtask
  task automatic put(input logic [1:0] i, input logic [63:0] d);
    @(posedge pclk); tbl_wr_en <= 1'b1; tbl_wr_idx <= i; tbl_wr_data <= d;
    @(posedge pclk); tbl_wr_en <= 1'b0;
  endtask
  task automatic cmd_rd(input logic [31:0] c, input logic [31:0] lo, input logic [31:0] hi);
    apb(1'b1, ATR_IDX_CMD, c);
    wait_sts(32'h1, 32'h0);
    apb(1'b0, ATR_IDX_RD_LO, 32'h0); check(r, lo);
    apb(1'b0, ATR_IDX_RD_HI, 32'h0); check(r, hi);
    check(r[ATR_B_EOT] | r[ATR_B_VALID], 1'b1);
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 16'h0; pwdata = 32'h0;
    tbl_wr_en = 0; tbl_wr_idx = 2'h0; tbl_wr_data = 64'h0; fwd_req = 0; fwd_idx = 2'h0;
    age_tick = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ATR_IDX_RD_LO, 32'h0); check(r, 32'h0000_0000);
    apb(1'b0, ATR_IDX_RD_HI, 32'h0); check(r, 32'h0000_0000);
    wait_sts(32'h2, 32'h2);
    put(2'h1, 64'h066E_BEEF_1234_5601);
    put(2'h3, 64'h0787_0A0B_CAFE_0002);
    apb(1'b1, ATR_IDX_CFG, 32'h1);
    cmd_rd(32'h1, 32'h1234_5601, 32'h066E_BEEF);
    // Read-only word must ignore a write
    apb(1'b1, ATR_IDX_RD_LO, 32'hFFFF_FFFF);
    apb(1'b0, ATR_IDX_RD_LO, 32'h0); check(r, 32'h1234_5601);
    // Valid drops at the command write, pending shows while searching
    apb(1'b1, ATR_IDX_CMD, 32'h2);
    apb(1'b0, ATR_IDX_STS, 32'h0); check(r & 32'h1, 32'h1);
    apb(1'b0, ATR_IDX_RD_HI, 32'h0); check(r[26], 1'b0);
    wait_sts(32'h1, 32'h0);
    apb(1'b0, ATR_IDX_RD_HI, 32'h0); check(r, 32'h0F87_0A0B);
    cmd_rd(32'h2, 32'h0, 32'h0800_0000);
    apb(1'b0, 14'h1807, 32'h0); check(r, 32'h0000_0000);
    check({31'h0, e}, 32'h0000_0001);
    // Forwarding view of static entry 3, then of entry 1 with priority
    @(posedge pclk); fwd_req <= 1'b1; fwd_idx <= 2'h3;
    @(posedge pclk); fwd_req <= 1'b0;
    wait_fwd();
    check({fwd_hit, fwd_discard, fwd_override, fwd_port_map}, 6'h3F);
    @(posedge pclk); fwd_req <= 1'b1; fwd_idx <= 2'h1;
    @(posedge pclk); fwd_req <= 1'b0;
    wait_fwd();
    check({fwd_prio_use, fwd_prio, fwd_multi, fwd_port_map}, 8'hDE);
    // Aging: one tick steps entry 1 from 10 to 01; two more remove it, static entry 3 stays
    tick();
    cmd_rd(32'h3, 32'h1234_5601, 32'h04EE_BEEF);
    tick();
    tick();
    cmd_rd(32'h1, 32'hCAFE_0002, 32'h0F87_0A0B);
    report_and_stop();
  end
  // One aging tick, then enough idle cycles for a four-entry sweep
  task automatic tick();
    @(posedge pclk);
    age_tick <= 1'b1;
    @(posedge pclk);
    age_tick <= 1'b0;
    repeat (20) @(posedge pclk);
  endtask
  task automatic wait_fwd();
    int n;
    n = 0;
    do begin @(posedge pclk); n++; end while (fwd_valid !== 1'b1 && n < 20);
    if (n >= 20) begin errors++; report_and_stop(); end
  endtask
endmodule
